// >>> logic/tms_pkg.sv
// package: register map, reset values, field layout and carrier types of the tdm setup block
package tms_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_SERIAL_IF_MODE = 8'h00; // line interface mode
    localparam logic [7:0] OFF_SERIAL_CLOCK_ROUTE = 8'h04; // clock routing
    localparam logic [7:0] OFF_GENERAL_MODE = 8'h08; // controller tx/rx enables
    localparam logic [7:0] OFF_EVENT = 8'h0C; // controller events, write one to clear
    localparam logic [7:0] OFF_EVENT_MASK = 8'h10; // controller event mask
    localparam logic [7:0] OFF_IRQ_SOURCE_MASK = 8'h14; // interrupt source mask
    localparam logic [7:0] OFF_PARAM_LAYOUT = 8'h18; // active logical channel count
    localparam logic [7:0] OFF_PARAM_STATUS = 8'h1C; // parameter ram usage, read only
    localparam logic [7:0] OFF_CHAN_BASE = 8'h20; // first channel mode register
    localparam int NUM_CHAN = 4; // channel mode registers held here

    // ****************************************************************
    // reset values and writable bit masks
    // ****************************************************************
    localparam logic [31:0] RST_ZERO = 32'h0000_0000; // every register resets to zero except the read-only parameter status
    localparam logic [31:0] MASK_IF_MODE = 32'h0000_001F; // implemented mode bits
    localparam logic [31:0] MASK_CLOCK_ROUTE = 32'h0000_00FF; // implemented route bits
    localparam logic [31:0] MASK_GENERAL = 32'h0000_0003; // tx and rx enable
    localparam logic [31:0] MASK_CHAN = 32'h0000_03FF; // channel mode bits
    localparam logic [31:0] MASK_NIBBLE = 32'h0000_000F; // event and mask width
    localparam logic [31:0] MASK_ONE = 32'h0000_0001; // single source bit
    localparam logic [31:0] MASK_COUNT = 32'h0000_007F; // channel count field

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int IFM_COMMON = 0; // common_rx_tx_clocking
    localparam int IFM_RXD_LO = 1; // rx_sync_delay, two bits
    localparam int IFM_TXD_LO = 3; // tx_sync_delay, two bits
    localparam int CR_GRANT = 0; // grant_mode_sel
    localparam int CR_TDM = 1; // tdm_connect_sel
    localparam int CR_RXCS_LO = 2; // rx_clock_source, three bits
    localparam int CR_TXCS_LO = 5; // tx_clock_source, three bits
    localparam int GM_TX = 0; // transmitter enable
    localparam int GM_RX = 1; // receiver enable

    // ****************************************************************
    // parameter ram layout
    // ****************************************************************
    localparam int MAX_CHANNELS = 64; // logical channels
    localparam int CHAN_SLOT_BYTES = 64; // parameter bytes per channel
    localparam int PAGE_BYTES = 256; // one parameter page
    localparam logic [12:0] CHAN_AREA_BYTES = 13'h1000; // lower channel area
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // ahb nonsequential

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic receive_on; // bit 9
        logic descriptor_scan_enable; // bit 8
        logic [3:0] flag_count; // bits 7:4, flags between frames
        logic crc32_sel; // bit 3, long frame check sequence
        logic transmit_on; // bit 2
        logic idle_fill_mode; // bit 1
        logic hdlc_mode; // bit 0
    } tms_chan_cfg_t;

    typedef struct packed {
        logic rx_clock; // line_rx_clock_pin
        logic tx_clock; // line_tx_clock_pin
        logic rx_sync; // receive frame sync
        logic tx_sync; // transmit frame sync
    } tms_line_t;

    typedef struct packed {
        logic route_tdm; // controller clocked from the tdm
        logic [2:0] rx_clock_sel; // effective receive clock source
        logic [2:0] tx_clock_sel; // effective transmit clock source
    } tms_route_t;
endpackage

// >>> logic/tms_setup.sv
// tdm multichannel setup: register bank, line framing and channel gating
// What this block does
// - line mode register resets to all zeros
// - common clocking: transmit uses receive clock, sync
// - receive delay one: frame one bit-clock later
// - transmit delay one: frame one bit-clock later
// - route register resets zero; grant, tdm, sources
// - channel transmit enable zero until software sets
// - crc select one picks 32-bit check sequence
// - flag count sets flags between frames
// - idle fill zero sends only flags between
// - events reset zero; write one clears bit
// - event requests only when both masks set
// - data moves only after general tx/rx enables
// - 64 channels fill whole lower 4-Kbyte area
// - pages are 256 bytes, reusable when disabled
// - each unused channel frees a 64-byte slot
`timescale 1ns/10ps
module tms_setup
    import tms_pkg::*;
(
    input wire logic hclk, // 250 MHz bus clock
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, words only
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic [31:0] hrdata, // read data
    input wire tms_pkg::tms_line_t line_pins, // asynchronous line inputs
    input wire logic [3:0] event_set, // engine event pulses
    input wire logic [NUM_CHAN-1:0] scan_done, // engine finished descriptor poll
    output tms_pkg::tms_chan_cfg_t chan_cfg [NUM_CHAN], // channel settings
    output logic [NUM_CHAN-1:0] chan_tx_allowed, // channel may transmit
    output logic [NUM_CHAN-1:0] chan_rx_allowed, // channel may receive
    output tms_pkg::tms_route_t route, // effective clock routing
    output logic rx_frame_start, // receive frame begins, pulse
    output logic tx_frame_start, // transmit frame begins, pulse
    output logic event_request, // masked event pending
    output logic page_reusable // controller page free for descriptors
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0] if_mode_reg, if_mode_next; // serial_if_mode_reg
    logic [31:0] clock_route_reg, clock_route_next; // serial_clock_route_reg
    logic [31:0] general_mode_reg, general_mode_next; // general_mode_reg
    logic [3:0] event_reg, event_next; // controller_event_reg
    logic [3:0] event_mask_reg, event_mask_next; // controller_event_mask
    logic irq_src_mask_reg, irq_src_mask_next; // irq_source_mask
    logic [6:0] active_chan_reg, active_chan_next; // logical channels in use
    logic [31:0] chan_mode_reg [NUM_CHAN]; // channel_mode_reg copies
    logic [31:0] chan_mode_next [NUM_CHAN];
    logic [7:0] dp_addr_reg, dp_addr_next; // data phase address
    logic dp_wr_reg, dp_wr_next; // data phase write
    logic dp_rd_reg, dp_rd_next; // data phase read
    logic rd_ready_reg, rd_ready_next; // read data captured
    logic [31:0] hrdata_reg, hrdata_next; // read data flop
    logic event_req_reg, event_req_next; // interrupt request flop
    logic [12:0] param_used; // bytes of channel area used
    logic [12:0] param_free; // bytes freed by unused channels
    logic [31:0] rd_value; // decoded read value

    // ****************************************************************
    // line input synchronisers
    // ****************************************************************
    logic [3:0] line_s1, line_s2, line_s3; // two stages, then edge history
    logic [1:0] delay_cnt_reg [2], delay_cnt_next [2]; // per side, 0 rx 1 tx
    logic [1:0] delay_busy_reg, delay_busy_next; // delay running
    logic [1:0] fstart_reg, fstart_next; // frame start pulses
    logic [1:0] side_edge, side_sync; // bit clock edge, sync level per side
    logic [1:0] side_delay [2]; // programmed delay per side

    // three flops per pin; the second stage and the third edge-history stage feed logic
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_s1 <= 4'h0;
            line_s2 <= 4'h0;
            line_s3 <= 4'h0;
        end
        else
        begin
            line_s1 <= line_pins;
            line_s2 <= line_s1;
            line_s3 <= line_s2;
        end
    end

    // ****************************************************************
    // frame start with sync delay
    // ****************************************************************
    // pick clock and sync for each side
    always_comb
    begin
        side_edge[0] = line_s2[3] & ~line_s3[3]; // receive clock rise
        side_sync[0] = line_s2[1];
        if (if_mode_reg[IFM_COMMON])
        begin
            side_edge[1] = side_edge[0];
            side_sync[1] = side_sync[0];
        end
        else
        begin
            side_edge[1] = line_s2[2] & ~line_s3[2]; // transmit clock rise
            side_sync[1] = line_s2[0];
        end
        side_delay[0] = if_mode_reg[IFM_RXD_LO +: 2];
        side_delay[1] = if_mode_reg[IFM_TXD_LO +: 2];
    end

    // sync seen on a bit-clock edge starts a countdown of whole bit clocks
    always_comb
    begin
        delay_busy_next = delay_busy_reg;
        fstart_next = 2'h0;
        for (int s = 0; s < 2; s++)
        begin
            delay_cnt_next[s] = delay_cnt_reg[s];
            if (side_edge[s])
            begin
                if (side_sync[s] && !delay_busy_reg[s])
                begin
                    if (side_delay[s] == 2'h0)
                        fstart_next[s] = 1'b1; // no delay: frame on this edge
                    else
                    begin
                        delay_cnt_next[s] = side_delay[s];
                        delay_busy_next[s] = 1'b1;
                    end
                end
                else if (delay_busy_reg[s])
                begin
                    delay_cnt_next[s] = delay_cnt_reg[s] - 2'h1;
                    if (delay_cnt_reg[s] == 2'h1)
                    begin
                        fstart_next[s] = 1'b1;
                        delay_busy_next[s] = 1'b0;
                    end
                end
            end
        end
    end

    // framing flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            delay_cnt_reg[0] <= 2'h0;
            delay_cnt_reg[1] <= 2'h0;
            delay_busy_reg <= 2'h0;
            fstart_reg <= 2'h0;
        end
        else
        begin
            delay_cnt_reg <= delay_cnt_next;
            delay_busy_reg <= delay_busy_next;
            fstart_reg <= fstart_next;
        end
    end

    // ****************************************************************
    // ahb-lite slave and register bank
    // ****************************************************************
    // parameter ram usage: one slot per active channel
    always_comb
    begin
        param_used = 13'(active_chan_reg) * 13'(CHAN_SLOT_BYTES);
        param_free = CHAN_AREA_BYTES - param_used;
    end

    // read decode; reserved bits come back as zero
    always_comb
    begin
        rd_value = RST_ZERO;
        case (dp_addr_reg)
            OFF_SERIAL_IF_MODE: rd_value = if_mode_reg & MASK_IF_MODE;
            OFF_SERIAL_CLOCK_ROUTE: rd_value = clock_route_reg & MASK_CLOCK_ROUTE;
            OFF_GENERAL_MODE: rd_value = general_mode_reg;
            OFF_EVENT: rd_value = {28'h0, event_reg};
            OFF_EVENT_MASK: rd_value = {28'h0, event_mask_reg};
            OFF_IRQ_SOURCE_MASK: rd_value = {31'h0, irq_src_mask_reg};
            OFF_PARAM_LAYOUT: rd_value = {25'h0, active_chan_reg};
            OFF_PARAM_STATUS: rd_value = {3'h0, param_free, 3'h0, param_used};
            default:
            begin
                for (int c = 0; c < NUM_CHAN; c++)
                    if (dp_addr_reg == OFF_CHAN_BASE + 8'(4 * c))
                        rd_value = chan_mode_reg[c];
            end
        endcase
    end

    // bus phases, register writes and hardware updates
    always_comb
    begin
        dp_addr_next = dp_addr_reg;
        dp_wr_next = 1'b0;
        dp_rd_next = dp_rd_reg;
        rd_ready_next = 1'b0;
        hrdata_next = hrdata_reg;
        if_mode_next = if_mode_reg;
        clock_route_next = clock_route_reg;
        general_mode_next = general_mode_reg;
        event_mask_next = event_mask_reg;
        irq_src_mask_next = irq_src_mask_reg;
        active_chan_next = active_chan_reg;
        chan_mode_next = chan_mode_reg;
        event_next = event_reg;
        // read data phase: one wait cycle while data is captured
        if (dp_rd_reg && !rd_ready_reg)
        begin
            hrdata_next = rd_value;
            rd_ready_next = 1'b1;
        end
        else if (dp_rd_reg)
            dp_rd_next = 1'b0;
        // write data phase
        if (dp_wr_reg)
        begin
            case (dp_addr_reg)
                OFF_SERIAL_IF_MODE: if_mode_next = hwdata & MASK_IF_MODE;
                OFF_SERIAL_CLOCK_ROUTE: clock_route_next = hwdata & MASK_CLOCK_ROUTE;
                OFF_GENERAL_MODE: general_mode_next = hwdata & MASK_GENERAL;
                OFF_EVENT: event_next = event_reg & ~hwdata[3:0];
                OFF_EVENT_MASK: event_mask_next = hwdata[3:0];
                OFF_IRQ_SOURCE_MASK: irq_src_mask_next = hwdata[0];
                OFF_PARAM_LAYOUT:
                begin
                    // clamp to the channel limit
                    if (hwdata[6:0] > 7'(MAX_CHANNELS))
                        active_chan_next = 7'(MAX_CHANNELS);
                    else
                        active_chan_next = hwdata[6:0];
                end
                default:
                begin
                    for (int c = 0; c < NUM_CHAN; c++)
                        if (dp_addr_reg == OFF_CHAN_BASE + 8'(4 * c))
                            chan_mode_next[c] = hwdata & MASK_CHAN;
                end
            endcase
        end
        // engine clears scan enable after polling; a software set wins
        for (int c = 0; c < NUM_CHAN; c++)
            if (scan_done[c] && !(chan_mode_next[c][8] && dp_wr_reg
                && dp_addr_reg == OFF_CHAN_BASE + 8'(4 * c)))
                chan_mode_next[c][8] = 1'b0;
        // new events win over a clear in the same cycle
        event_next = event_next | event_set;
        // address phase accepted
        if (hsel && hready && htrans == HTRANS_NONSEQ)
        begin
            dp_addr_next = haddr[7:0];
            dp_wr_next = hwrite;
            dp_rd_next = !hwrite;
        end
        event_req_next = |(event_reg & event_mask_reg) & irq_src_mask_reg;
    end

    // register bank flops, all cleared by reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            if_mode_reg <= RST_ZERO;
            clock_route_reg <= RST_ZERO;
            general_mode_reg <= RST_ZERO;
            event_reg <= 4'h0;
            event_mask_reg <= 4'h0;
            irq_src_mask_reg <= 1'b0;
            active_chan_reg <= 7'h0;
            for (int c = 0; c < NUM_CHAN; c++)
                chan_mode_reg[c] <= RST_ZERO;
            dp_addr_reg <= 8'h0;
            dp_wr_reg <= 1'b0;
            dp_rd_reg <= 1'b0;
            rd_ready_reg <= 1'b0;
            hrdata_reg <= RST_ZERO;
            event_req_reg <= 1'b0;
        end
        else
        begin
            if_mode_reg <= if_mode_next;
            clock_route_reg <= clock_route_next;
            general_mode_reg <= general_mode_next;
            event_reg <= event_next;
            event_mask_reg <= event_mask_next;
            irq_src_mask_reg <= irq_src_mask_next;
            active_chan_reg <= active_chan_next;
            chan_mode_reg <= chan_mode_next;
            dp_addr_reg <= dp_addr_next;
            dp_wr_reg <= dp_wr_next;
            dp_rd_reg <= dp_rd_next;
            rd_ready_reg <= rd_ready_next;
            hrdata_reg <= hrdata_next;
            event_req_reg <= event_req_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // stall only during the read capture cycle
    always_comb
    begin
        hreadyout = !(dp_rd_reg && !rd_ready_reg);
        hresp = 1'b0;
        hrdata = hrdata_reg;
        rx_frame_start = fstart_reg[0];
        tx_frame_start = fstart_reg[1];
        event_request = event_req_reg;
        // page free for descriptors while the controller is disabled
        page_reusable = ~(general_mode_reg[GM_TX] | general_mode_reg[GM_RX]);
    end

    // effective clock routing
    always_comb
    begin
        route.route_tdm = clock_route_reg[CR_TDM];
        if (clock_route_reg[CR_TDM])
        begin
            route.rx_clock_sel = 3'h0;
            route.tx_clock_sel = 3'h0;
        end
        else
        begin
            route.rx_clock_sel = clock_route_reg[CR_RXCS_LO +: 3];
            route.tx_clock_sel = clock_route_reg[CR_TXCS_LO +: 3];
        end
    end

    // per channel settings and data gating
    always_comb
    begin
        for (int c = 0; c < NUM_CHAN; c++)
        begin
            chan_cfg[c] = chan_mode_reg[c][9:0];
            chan_tx_allowed[c] = general_mode_reg[GM_TX] & chan_mode_reg[c][2];
            chan_rx_allowed[c] = general_mode_reg[GM_RX] & chan_mode_reg[c][9];
        end
    end
endmodule

// >>> test/tms_setup_checker.sv
// checker: port-level assertions of the tdm setup block
`timescale 1ns/10ps
module tms_setup_checker
    import tms_pkg::*;
(
    input wire logic hclk, // bus clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // read data
    input wire tms_pkg::tms_line_t line_pins, // line pins
    input wire logic [3:0] event_set, // event pulses
    input wire logic [NUM_CHAN-1:0] scan_done, // poll done
    input wire tms_pkg::tms_chan_cfg_t chan_cfg [NUM_CHAN], // channel settings
    input wire logic [NUM_CHAN-1:0] chan_tx_allowed, // tx gate
    input wire logic [NUM_CHAN-1:0] chan_rx_allowed, // rx gate
    input wire tms_pkg::tms_route_t route, // clock routing
    input wire logic rx_frame_start, // rx frame pulse
    input wire logic tx_frame_start, // tx frame pulse
    input wire logic event_request, // event request
    input wire logic page_reusable // page free
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read costs one wait cycle, then data
    AST_READ_WAIT: assert property (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase timing wrong");
    // channel 0 may transmit or receive only when its own enable is set
    AST_TX_GATE: assert property (chan_tx_allowed[0] |-> chan_cfg[0].transmit_on)
        else $error("tx allowed without channel enable");
    AST_RX_GATE: assert property (chan_rx_allowed[0] |-> chan_cfg[0].receive_on)
        else $error("rx allowed without channel enable");
    // tdm connect hides both clock source fields
    AST_ROUTE_TDM: assert property (route.route_tdm |-> route.rx_clock_sel == 3'h0 && route.tx_clock_sel == 3'h0)
        else $error("clock source not overridden by tdm connect");
    AST_PAGE_BUSY: assert property ((chan_tx_allowed != '0) || (chan_rx_allowed != '0) |-> !page_reusable)
        else $error("page reusable while controller runs");
    AST_RX_PULSE: assert property (rx_frame_start |=> !rx_frame_start)
        else $error("rx frame start longer than one cycle");
    AST_TX_PULSE: assert property (tx_frame_start |=> !tx_frame_start)
        else $error("tx frame start longer than one cycle");
    // a receive frame starts only behind a bit clock rise
    AST_FRAME_CLOCK: assert property (rx_frame_start |-> $past(line_pins.rx_clock, 2))
        else $error("rx frame start without bit clock");
    COV_READ: cover property (hsel && htrans == HTRANS_NONSEQ && !hwrite);
    COV_FRAME: cover property (rx_frame_start ##[1:40] tx_frame_start);
    COV_EVENT: cover property (event_request);
endmodule

bind tms_setup tms_setup_checker tms_setup_checker_inst (.*);

// >>> test/tms_line_model.sv
// line model: tdm highway bit clock and frame sync
`timescale 1ns/10ps
// ****************************************************************
// highway transceiver side
// ****************************************************************
module tms_line_model
    import tms_pkg::*;
(
    input wire logic run, // frames flow while high
    input wire logic tx_mute, // transmit pins stand still
    output tms_pkg::tms_line_t line_pins // line pins
);
    logic clk_q; // bit clock
    logic sync_q; // frame sync
    int bit_no; // bit within frame
    // 64 ns bit clock, sync high across one rise every eight bits
    initial
    begin
        clk_q = 1'b0;
        sync_q = 1'b0;
        bit_no = 0;
        #7;
        forever
        begin
            #32;
            clk_q = run ? ~clk_q : 1'b0; // stands low while run is low
            if (!run)
                sync_q = 1'b0;
            else if (!clk_q)
            begin
                bit_no = (bit_no + 1) % 8;
                sync_q = (bit_no == 0);
            end
        end
    end
    // muted tx pins expose common clocking; strobes sit on one port only
    assign line_pins = '{rx_clock: clk_q, tx_clock: clk_q & ~tx_mute, rx_sync: sync_q,
        tx_sync: sync_q & ~tx_mute};
endmodule

// >>> test/tms_setup_tb.sv
// testbench: register bank, channel gating and framing of the tdm setup block
`timescale 1ns/10ps
module tms_setup_tb;
    import tms_pkg::*;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:0] event_set = 4'h0; // event pulses
    logic [3:0] scan_done = 4'h0; // poll done
    logic run = 1'b0; // frames flow
    logic tx_mute = 1'b1; // tx pins silent
    logic hreadyout, hresp, rx_frame_start, tx_frame_start, event_request, page_reusable;
    logic [31:0] hrdata;
    logic [NUM_CHAN-1:0] chan_tx_allowed, chan_rx_allowed; // gates
    tms_line_t line_pins;
    tms_chan_cfg_t chan_cfg [NUM_CHAN];
    tms_route_t route;
    int err_count = 0; // mismatches
    int compares = 0; // comparisons

    always #2 hclk = ~hclk;

    tms_setup tms_setup_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_pins(line_pins),
        .event_set(event_set), .scan_done(scan_done), .chan_cfg(chan_cfg),
        .chan_tx_allowed(chan_tx_allowed), .chan_rx_allowed(chan_rx_allowed), .route(route),
        .rx_frame_start(rx_frame_start), .tx_frame_start(tx_frame_start),
        .event_request(event_request), .page_reusable(page_reusable));
    tms_line_model tms_line_model_inst (.run(run), .tx_mute(tx_mute), .line_pins(line_pins));

    task wrap_up;
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for hreadyout
    task wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_count++;
            wrap_up;
        end
    endtask

    // address phase, then data phase
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, RST_ZERO);
        check(hrdata, e);
    endtask

    task settle;
        repeat (2) @(posedge hclk);
    endtask

    // cycles from sync-sampling rise to frame start
    task gap(input logic tx, input int lo, input int hi);
        int n;
        logic pc;
        logic rise;
        n = 0;
        pc = 1'b1;
        do
        begin
            @(posedge hclk);
            rise = line_pins.rx_clock & ~pc & line_pins.rx_sync;
            pc = line_pins.rx_clock;
            n++;
        end
        while (!rise && n < 400);
        if (n >= 400)
            err_count++;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while ((tx ? tx_frame_start : rx_frame_start) !== 1'b1 && n < 60);
        check(32'(n >= lo && n <= hi), MASK_ONE);
    endtask

    initial
    begin
        int n;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 48; a += 4)
            rd(8'(a), (a == 28) ? 32'h1000_0000 : RST_ZERO);
        bus(1'b1, 8'h30, 32'hFFFF_FFFF);
        rd(8'h30, RST_ZERO);
        bus(1'b1, OFF_SERIAL_IF_MODE, 32'hFFFF_FFFF);
        rd(OFF_SERIAL_IF_MODE, MASK_IF_MODE);
        bus(1'b1, OFF_SERIAL_CLOCK_ROUTE, 32'hFFFF_FFFF);
        rd(OFF_SERIAL_CLOCK_ROUTE, MASK_CLOCK_ROUTE);
        check(32'(route), 32'h0000_0040);
        bus(1'b1, OFF_SERIAL_CLOCK_ROUTE, 32'h0000_009C);
        settle;
        check(32'(route), 32'h0000_003C);
        bus(1'b1, OFF_CHAN_BASE, 32'h0000_037D);
        rd(OFF_CHAN_BASE, 32'h0000_037D);
        check(32'(chan_cfg[0]), 32'h0000_037D);
        check(32'(chan_tx_allowed), RST_ZERO);
        bus(1'b1, OFF_GENERAL_MODE, 32'h0000_0003);
        settle;
        check(32'(chan_tx_allowed), MASK_ONE);
        check(32'(chan_rx_allowed), MASK_ONE);
        check(32'(page_reusable), RST_ZERO);
        scan_done <= 4'h1;
        event_set <= 4'hF;
        @(posedge hclk);
        scan_done <= 4'h0;
        event_set <= 4'h0;
        rd(OFF_CHAN_BASE, 32'h0000_027D);
        rd(OFF_EVENT, MASK_NIBBLE);
        bus(1'b1, OFF_EVENT, 32'h0000_0005);
        rd(OFF_EVENT, 32'h0000_000A);
        bus(1'b1, OFF_EVENT_MASK, MASK_NIBBLE);
        settle;
        check(32'(event_request), RST_ZERO);
        bus(1'b1, OFF_IRQ_SOURCE_MASK, MASK_ONE);
        settle;
        check(32'(event_request), MASK_ONE);
        bus(1'b1, OFF_EVENT, MASK_NIBBLE);
        settle;
        check(32'(event_request), RST_ZERO);
        bus(1'b1, OFF_PARAM_LAYOUT, 32'h0000_0040);
        rd(OFF_PARAM_STATUS, 32'h0000_1000);
        bus(1'b1, OFF_PARAM_LAYOUT, 32'h0000_003F);
        rd(OFF_PARAM_STATUS, 32'h0040_0FC0);
        bus(1'b1, OFF_GENERAL_MODE, RST_ZERO);
        settle;
        check(32'(page_reusable), MASK_ONE);
        bus(1'b1, OFF_SERIAL_IF_MODE, 32'h0000_000A);
        run <= 1'b1;
        gap(1'b0, 18, 22);
        n = 0;
        repeat (300)
        begin
            @(posedge hclk);
            n += int'(tx_frame_start === 1'b1);
        end
        check(32'(n), RST_ZERO);
        run <= 1'b0;
        bus(1'b1, OFF_SERIAL_IF_MODE, 32'h0000_000B);
        run <= 1'b1;
        gap(1'b1, 18, 22);
        run <= 1'b0;
        bus(1'b1, OFF_SERIAL_IF_MODE, MASK_ONE);
        run <= 1'b1;
        gap(1'b0, 2, 6);
        wrap_up;
    end
endmodule
